//--- design/sas_conv_tick.sv
// sas_conv_tick: converter clock tick generator for the core clock
`timescale 1ns/1ps
`default_nettype none
module sas_conv_tick
  import sas_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic run_i,
  output logic      tick_o
);
  typedef struct packed {
    logic [3:0] cnt;
  } sas_tick_st_type;

  sas_tick_st_type st_r;
  sas_tick_st_type st_nxt;

  // keeps the converter rate at or below its ceiling
  always_comb begin
    st_nxt = st_r;
    if (!run_i || st_r.cnt == CONV_DIV_L - 4'h1) begin
      st_nxt.cnt = 4'h0;
    end else begin
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = run_i && (st_r.cnt == CONV_DIV_L - 4'h1);
endmodule : sas_conv_tick
`default_nettype wire

//--- design/sas_pkg.sv
// sas_pkg: constants, register map and carrier types of the sequencer
package sas_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned RES_W      = 12;
  localparam int unsigned CH_MAX     = 16;
  localparam int unsigned CH_BASE    = 8;
  localparam int unsigned CH_W       = 5;   // 16 pins + temperature sensor
  localparam int unsigned SMP_W      = 8;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ   = 125000000;
  localparam int unsigned CONV_CLK_MAXHZ = 18000000;
  // converter clock period: core cycles per converter tick, rounded up
  localparam int unsigned CONV_DIV   =
    (CORE_CLK_HZ + CONV_CLK_MAXHZ - 1) / CONV_CLK_MAXHZ;
  localparam logic [3:0] CONV_DIV_L  = 4'(CONV_DIV);
  localparam int unsigned CONV_TICKS = 18;
  localparam logic [4:0] CONV_TICKS_L = 5'(CONV_TICKS);

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CHEN    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RANGE   = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_RANGEST = 8'h10;
  localparam logic [ADDR_W-1:0] REG_MANCH   = 8'h14;
  localparam logic [ADDR_W-1:0] REG_SMP_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] REG_RES_BASE = 8'h80;

  // ctrl fields
  localparam int unsigned CTRL_START = 0;  // write-one pulse
  localparam int unsigned CTRL_CONT  = 1;
  localparam int unsigned CTRL_MAN   = 2;
  localparam int unsigned CTRL_EXT16 = 3;
  localparam int unsigned CTRL_TEMP  = 4;
  localparam int unsigned CTRL_REF_L = 5;  // two bits

  localparam logic [SMP_W-1:0] SMP_RST    = 8'h03;
  localparam logic [RES_W-1:0] LIM_LO_RST = 12'h000;
  localparam logic [RES_W-1:0] LIM_HI_RST = 12'hfff;

  typedef enum logic [1:0] {
    SAS_REF_VDD  = 2'h0,
    SAS_REF_HALF = 2'h1,
    SAS_REF_INT  = 2'h2,
    SAS_REF_EXT  = 2'h3
  } sas_ref_type;

  // request to the analog core
  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic            sample;
    logic            convert;
    sas_ref_type     vref;
  } sas_ana_req_type;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sas_bus_req_type;

endpackage : sas_pkg

//--- design/sas_range_chk.sv
// sas_range_chk: window compare of a converted value
`timescale 1ns/1ps
`default_nettype none
module sas_range_chk
  import sas_pkg::*;
(
  input  wire logic [RES_W-1:0] value_i,
  input  wire logic [RES_W-1:0] lim_lo_i,
  input  wire logic [RES_W-1:0] lim_hi_i,
  output logic                  out_o
);
  assign out_o = (value_i < lim_lo_i) || (value_i > lim_hi_i);
endmodule : sas_range_chk
`default_nettype wire

//--- design/sas_seq_ctrl.sv
// sas_seq_ctrl: scan sequencer, result buffers and register port
//
// Overview of operation
// RULE1: every conversion gets at least 18 converter clock ticks.
// RULE2: converter ticks never come faster than 18 MHz.
// RULE3: eight pin channels, extendable to sixteen.
// RULE4: once started, the scan walks all enabled channels alone.
// RULE5: the next channel's sampling starts right after a conversion.
// RULE6: channel is chosen by the scanner or by software directly.
// RULE7: every channel has its own result buffer.
// RULE8: every channel has its own sample time, applied on conversion.
// RULE9: each result is checked against low and high limits.
// RULE10: the range flag rises as soon as the bad conversion ends.
// RULE11: reference is supply, half supply, internal or external.
// RULE12: the sample-and-hold window length is programmable.
// RULE13: the temperature sensor can be picked as an input.
// RULE14: deep low-power states stop and block the converter.
// RULE15: the range flag stays until software clears it.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sas_seq_ctrl
  import sas_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [DATA_W-1:0]     wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [DATA_W-1:0]     rdata_o,
  input  wire logic                  deep_lp_i,
  output sas_ana_req_type            ana_o,
  input  wire logic [RES_W-1:0]      ana_result_i,
  output logic                       busy_o,
  output logic                       range_irq_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SAS_IDLE = 3'b001,
    SAS_SMP  = 3'b010,
    SAS_CONV = 3'b100
  } sas_fsm_type;

  typedef struct packed {
    sas_fsm_type                   fsm;
    logic [CH_W-1:0]               chan;
    logic [SMP_W-1:0]              smp_cnt;
    logic [4:0]                    conv_cnt;
    logic                          cont;
    logic                          man;
    logic                          ext16;
    logic                          temp;
    sas_ref_type                   vref;
    logic [CH_MAX-1:0]             chen;
    logic [CH_W-1:0]               man_ch;
    logic [RES_W-1:0]              lim_lo;
    logic [RES_W-1:0]              lim_hi;
    logic [CH_MAX:0]               range_st;
    logic [CH_MAX:0]               valid;
    logic                          scan_done;
    logic [DATA_W-1:0]             rdata;
  } sas_st_type;

  sas_st_type st_r;
  sas_st_type st_nxt;

  // per-channel memories, slot CH_MAX is the temperature sensor
  logic [SMP_W-1:0] smp_r   [CH_MAX+1];
  logic [RES_W-1:0] res_r   [CH_MAX+1];

  logic tick;
  logic out_of_range;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // next enabled channel above cur, no wrap; lowest enabled one if from_top; returns CH_MAX if none
  function automatic logic [CH_W-1:0] next_ch(
    input logic [CH_MAX-1:0] en,
    input logic [CH_W-1:0]   cur,
    input logic              wide,
    input logic              from_top
  );
    logic [CH_W-1:0] r;
    logic [CH_W-1:0] lim;
    logic [CH_W-1:0] k;
    r   = CH_W'(CH_MAX);
    // RULE3 eight or sixteen pins
    lim = wide ? CH_W'(CH_MAX) : CH_W'(CH_BASE);
    for (int i = CH_MAX; i >= 1; i--) begin
      k = from_top ? CH_W'(i - 1) : CH_W'((int'(cur) + i) % CH_MAX);
      if (k < lim && en[k[3:0]] && (from_top || k > cur)) begin
        r = k;
      end
    end
    return r;
  endfunction : next_ch

  function automatic logic is_slot(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] base
  );
    return a >= base && a < base + ADDR_W'((CH_MAX + 1) * 4)
           && a[1:0] == 2'h0;
  endfunction : is_slot

  // ---------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------
  // RULE2 capped tick
  sas_conv_tick u_tick (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .run_i      (st_r.fsm != SAS_IDLE),
    .tick_o     (tick)
  );

  // RULE9 window compare
  sas_range_chk u_range (
    .value_i  (ana_result_i),
    .lim_lo_i (st_r.lim_lo),
    .lim_hi_i (st_r.lim_hi),
    .out_o    (out_of_range)
  );

  logic [CH_W-1:0] first_ch;
  logic [CH_W-1:0] after_ch;
  logic [CH_W-1:0] slot_w;
  logic [CH_W-1:0] slot_r;
  logic            start_req;
  // a start that also sets the wide option scans the wide set
  assign first_ch  = next_ch(st_r.chen, '0,
                             start_req ? wdata_i[CTRL_EXT16] : st_r.ext16,
                             1'b1);
  assign after_ch  = next_ch(st_r.chen, st_r.chan, st_r.ext16, 1'b0);
  assign slot_w    = CH_W'((addr_i - REG_SMP_BASE) >> 2);
  assign slot_r    = CH_W'((addr_i - REG_RES_BASE) >> 2);
  assign start_req = wr_i && addr_i == REG_CTRL && wdata_i[CTRL_START];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [CH_W-1:0] pick;
    logic [CH_MAX:0] set_rng;
    logic            done_now;
    st_nxt   = st_r;
    pick     = '0;
    set_rng  = '0;
    done_now = 1'b0;

    // register writes
    if (wr_i) begin
      unique case (addr_i)
        REG_CTRL: begin
          st_nxt.cont  = wdata_i[CTRL_CONT];
          st_nxt.man   = wdata_i[CTRL_MAN];
          st_nxt.ext16 = wdata_i[CTRL_EXT16];
          st_nxt.temp  = wdata_i[CTRL_TEMP];
          // RULE11 four references
          st_nxt.vref  = sas_ref_type'(wdata_i[CTRL_REF_L +: 2]);
        end
        REG_CHEN:    st_nxt.chen = wdata_i[CH_MAX-1:0];
        REG_RANGE: begin
          st_nxt.lim_lo = wdata_i[RES_W-1:0];
          st_nxt.lim_hi = wdata_i[16 +: RES_W];
        end
        // RULE15 write one to clear
        REG_RANGEST: st_nxt.range_st = st_r.range_st & ~wdata_i[CH_MAX:0];
        REG_STATUS:  st_nxt.scan_done = st_r.scan_done & ~wdata_i[0];
        REG_MANCH:   st_nxt.man_ch = wdata_i[CH_W-1:0];
        default: ;
      endcase
    end

    unique case (st_r.fsm)
      SAS_IDLE: begin
        // RULE14 no start in deep low power
        if (start_req && !deep_lp_i) begin
          // RULE6 firmware or scanner choice
          // RULE13 temperature sensor input
          if (wdata_i[CTRL_TEMP]) begin
            pick = CH_W'(CH_MAX);
          end else if (wdata_i[CTRL_MAN]) begin
            pick = st_r.man_ch;
          end else begin
            pick = first_ch;
          end
          // a manual pick past the pins would index beyond the tables
          if (pick < CH_W'(CH_MAX) || wdata_i[CTRL_TEMP]) begin
            st_nxt.fsm     = SAS_SMP;
            st_nxt.chan    = pick;
            // RULE8 RULE12 per-channel sample window
            st_nxt.smp_cnt = smp_r[pick];
          end
        end
      end
      SAS_SMP: begin
        if (tick) begin
          if (st_r.smp_cnt == '0) begin
            st_nxt.fsm      = SAS_CONV;
            st_nxt.conv_cnt = '0;
          end else begin
            st_nxt.smp_cnt = st_r.smp_cnt - SMP_W'(1);
          end
        end
      end
      SAS_CONV: begin
        // RULE1 hold for full conversion ticks
        if (tick && st_r.conv_cnt == CONV_TICKS_L - 5'h1) begin
          // RULE10 flag at end of each conversion
          if (out_of_range) begin
            set_rng[st_r.chan] = 1'b1;
          end
          st_nxt.valid[st_r.chan] = 1'b1;
          // RULE4 RULE5 go straight to next channel
          if (st_r.temp || st_r.man) begin
            done_now = 1'b1;
            st_nxt.fsm = st_r.cont ? SAS_SMP : SAS_IDLE;
            st_nxt.smp_cnt = smp_r[st_r.chan];
          end else if (after_ch == CH_W'(CH_MAX)) begin
            // last enabled channel: scan done, wrap in continuous mode
            done_now       = 1'b1;
            st_nxt.chan    = first_ch;
            st_nxt.smp_cnt = smp_r[first_ch];
            st_nxt.fsm     = (st_r.cont && first_ch != CH_W'(CH_MAX))
                             ? SAS_SMP : SAS_IDLE;
          end else begin
            st_nxt.chan    = after_ch;
            st_nxt.smp_cnt = smp_r[after_ch];
            st_nxt.fsm     = SAS_SMP;
          end
        end else if (tick) begin
          st_nxt.conv_cnt = st_r.conv_cnt + 5'h1;
        end
      end
      default: st_nxt.fsm = SAS_IDLE;
    endcase

    // RULE14 stopped clock aborts conversion
    if (deep_lp_i) begin
      st_nxt.fsm = SAS_IDLE;
    end

    // RULE15 set wins over clear
    st_nxt.range_st = st_nxt.range_st | set_rng;
    if (done_now) begin
      st_nxt.scan_done = 1'b1;
    end

    // read data, one cycle later
    st_nxt.rdata = '0;
    if (rd_i) begin
      if (is_slot(addr_i, REG_RES_BASE)) begin
        st_nxt.rdata = DATA_W'({st_r.valid[slot_r], 3'h0, res_r[slot_r]});
      end else if (is_slot(addr_i, REG_SMP_BASE)) begin
        st_nxt.rdata = DATA_W'(smp_r[slot_w]);
      end else begin
        unique case (addr_i)
          REG_CTRL: st_nxt.rdata = DATA_W'({st_r.vref, st_r.temp,
                                            st_r.ext16, st_r.man,
                                            st_r.cont, 1'b0});
          REG_CHEN:    st_nxt.rdata = DATA_W'(st_r.chen);
          REG_STATUS:  st_nxt.rdata = DATA_W'({st_r.chan,
                                         st_r.fsm != SAS_IDLE,
                                         st_r.scan_done});
          REG_RANGE:   st_nxt.rdata = DATA_W'({4'h0, st_r.lim_hi,
                                         4'h0, st_r.lim_lo});
          REG_RANGEST: st_nxt.rdata = DATA_W'(st_r.range_st);
          REG_MANCH:   st_nxt.rdata = DATA_W'(st_r.man_ch);
          default:     st_nxt.rdata = '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_r        <= '0;
      st_r.fsm    <= SAS_IDLE;
      st_r.lim_lo <= LIM_LO_RST;
      st_r.lim_hi <= LIM_HI_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // RULE7 RULE8 per-channel memories
  for (genvar g = 0; g <= CH_MAX; g++) begin : g_ch
    always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
        smp_r[g] <= SMP_RST;
        res_r[g] <= '0;
      end else begin
        if (wr_i && is_slot(addr_i, REG_SMP_BASE) && slot_w == CH_W'(g)) begin
          smp_r[g] <= wdata_i[SMP_W-1:0];
        end
        if (st_r.fsm == SAS_CONV && tick
            && st_r.conv_cnt == CONV_TICKS_L - 5'h1
            && st_r.chan == CH_W'(g)) begin
          res_r[g] <= ana_result_i;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata_o          = st_r.rdata;
  assign ana_o.chan       = st_r.chan;
  assign ana_o.sample     = st_r.fsm == SAS_SMP;
  assign ana_o.convert    = st_r.fsm == SAS_CONV;
  assign ana_o.vref       = st_r.vref;
  assign busy_o           = st_r.fsm != SAS_IDLE;
  // RULE9 interrupt line
  assign range_irq_o      = |st_r.range_st;

endmodule : sas_seq_ctrl
`default_nettype wire

//--- tb/sas_ana_model.sv
// sas_ana_model: behavioural mux and converter core
`timescale 1ns/1ps
`default_nettype none
module sas_ana_model
  import sas_pkg::*;
(
  input  wire logic            core_clk_i,
  input  wire sas_ana_req_type ana_i,
  output logic [RES_W-1:0]     result_o
);
  logic [RES_W-1:0] last_r = 12'h000;
  // temperature sensor gives its own value
  // pin value tells which channel was muxed
  always_ff @(posedge core_clk_i) begin
    if (ana_i.convert)
      last_r <= (ana_i.chan == 5'h10) ? 12'hf05 : {ana_i.chan[3:0], 8'h05};
    else
      last_r <= ~last_r;  // no stale value outside a conversion
  end
  assign result_o = last_r;
endmodule : sas_ana_model
`default_nettype wire

//--- tb/sas_seq_ctrl_bench.sv
// sas_seq_ctrl_bench: register-level regression of the sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); fails++; end end
module sas_seq_ctrl_bench;
  import sas_pkg::*;
  logic              core_clk_i = 1'b0;
  logic              nrst_i     = 1'b0;
  logic [ADDR_W-1:0] addr_i     = 8'h00;
  logic [DATA_W-1:0] wdata_i    = 32'h0;
  logic              wr_i       = 1'b0;
  logic              rd_i       = 1'b0;
  logic              deep_lp_i  = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  sas_ana_req_type   ana_o;
  logic [RES_W-1:0]  ana_result_i;
  logic              busy_o;
  logic              range_irq_o;
  int                fails   = 0;
  int                n_tests = 0;
  int                cyc     = 0;
  int                smp9_n  = 0;
  logic [DATA_W-1:0] d;

  always #4 core_clk_i = ~core_clk_i;

  sas_seq_ctrl DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .deep_lp_i(deep_lp_i), .ana_o(ana_o),
    .ana_result_i(ana_result_i), .busy_o(busy_o),
    .range_irq_o(range_irq_o));
  sas_ana_model u_ana (.core_clk_i(core_clk_i), .ana_i(ana_o),
    .result_o(ana_result_i));

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd

  // bounded wait of up to 3002 cycles for busy_o low; going busy first is not checked
  task automatic wait_idle();
    repeat (2) @(posedge core_clk_i);
    for (int i = 0; i < 3000; i++) begin
      @(posedge core_clk_i);
      #1;
      if (busy_o === 1'b0) break;
    end
  endtask : wait_idle

  task automatic results();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // hang guard: full run needs well under 5000 cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  // sample-phase cycles spent on channel nine
  always @(posedge core_clk_i) begin
    if (nrst_i && ana_o.sample && ana_o.chan == 5'h09) smp9_n++;
  end

  initial begin
    repeat (10) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    // ---------------------------------------------------------------
    // reset values and unmapped address
    // ---------------------------------------------------------------
    rd(REG_SMP_BASE, d); `CHK("smp0", {24'h0, SMP_RST}, d)
    rd(REG_RANGE, d); `CHK("range", 32'h0fff0000, d)
    rd(8'hfc, d); `CHK("unmapped", 32'h0, d)
    `CHK("irq_rst", 1'b0, range_irq_o)
    $display("test reset done");
    // reference choices
    for (int r = 0; r < 4; r++) begin
      wr(REG_CTRL, 32'(r) << CTRL_REF_L);
      @(posedge core_clk_i);
      #1;
      `CHK("vref", sas_ref_type'(r), ana_o.vref)
    end
    $display("test reference done");
    // ---------------------------------------------------------------
    // autonomous scan over 0, 1 and extended 9
    // ---------------------------------------------------------------
    wr(REG_RANGE, 32'h0e000100);
    wr(REG_SMP_BASE + 8'h04, 32'h0);
    wr(REG_SMP_BASE + 8'h24, 32'h10);
    wr(REG_CHEN, 32'h0203);
    wr(REG_CTRL, 32'h9);
    wait_idle();
    `CHK("busy_end", 1'b0, busy_o)
    rd(REG_RES_BASE, d); `CHK("res0", 32'h8005, d)
    rd(REG_RES_BASE + 8'h04, d); `CHK("res1", 32'h8105, d)
    rd(REG_RES_BASE + 8'h24, d); `CHK("res9", 32'h8905, d)
    `CHK("smp9_len", (16 + 1) * CONV_DIV, smp9_n)
    rd(REG_RANGEST, d); `CHK("rst_scan", 32'h1, d)
    `CHK("irq_on", 1'b1, range_irq_o)
    rd(REG_STATUS, d); `CHK("done", 1'b1, d[0])
    wr(REG_RANGEST, 32'h1);
    @(posedge core_clk_i);
    #1;
    `CHK("irq_clr", 1'b0, range_irq_o)
    $display("test scan done");
    // ---------------------------------------------------------------
    // software-chosen temperature channel, then pin 5
    // ---------------------------------------------------------------
    wr(REG_MANCH, 32'h10);
    wr(REG_CTRL, 32'h15);
    wait_idle();
    rd(REG_RES_BASE + 8'h40, d); `CHK("temp", 32'h8f05, d)
    rd(REG_RANGEST, d); `CHK("rst_temp", 32'h10000, d)
    wr(REG_MANCH, 32'h5);
    wr(REG_CTRL, 32'h5);
    wait_idle();
    rd(REG_RES_BASE + 8'h14, d); `CHK("res5", 32'h8505, d)
    $display("test manual done");
    // ---------------------------------------------------------------
    // continuous scan keeps running until the mode is cleared
    // ---------------------------------------------------------------
    wr(REG_CHEN, 32'h4);
    wr(REG_CTRL, 32'h3);
    repeat (400) @(posedge core_clk_i);
    #1;
    `CHK("cont_busy", 1'b1, busy_o)
    wr(REG_CTRL, 32'h0);
    wait_idle();
    `CHK("cont_stop", 1'b0, busy_o)
    rd(REG_RES_BASE + 8'h08, d); `CHK("res2", 32'h8205, d)
    $display("test continuous done");
    // ---------------------------------------------------------------
    // start refused in deep low power
    // ---------------------------------------------------------------
    wr(REG_RANGEST, 32'h1ffff);
    deep_lp_i <= 1'b1;
    wr(REG_CTRL, 32'h1);
    repeat (3) @(posedge core_clk_i);
    deep_lp_i <= 1'b0;
    #1;
    `CHK("lp_busy", 1'b0, busy_o)
    wr(REG_CTRL, 32'h1);
    repeat (20) @(posedge core_clk_i);
    deep_lp_i <= 1'b1;
    #1;
    `CHK("lp_run", 1'b1, busy_o)
    @(posedge core_clk_i);
    #1;
    `CHK("lp_abort", 1'b0, busy_o)
    $display("test low power done");
    results();
  end
endmodule : sas_seq_ctrl_bench
`default_nettype wire

//--- tb/sas_seq_ctrl_sva.sv
// sas_seq_ctrl_sva: port-level checker for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module sas_seq_ctrl_sva
  import sas_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic [DATA_W-1:0] rdata_o,
  input  wire logic              deep_lp_i,
  input  wire sas_ana_req_type   ana_o,
  input  wire logic [RES_W-1:0]  ana_result_i,
  input  wire logic              busy_o,
  input  wire logic              range_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // length of the running convert phase, in core cycles
  logic [7:0] conv_len_r;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || !ana_o.convert) conv_len_r <= 8'h00;
    else if (conv_len_r != 8'hff) conv_len_r <= conv_len_r + 8'h01;
  end

  sequence conv_end;
    $fell(ana_o.convert);
  endsequence
  sequence conv_begin;
    $rose(ana_o.convert);
  endsequence

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // a deep low-power abort may legally cut a conversion short
  a_conv_min_len: assert property (conv_end && !$past(deep_lp_i)
    |-> conv_len_r >= 8'h7e)
    else $error("conversion shorter than eighteen converter ticks");
  a_busy_idle_quiet: assert property (!busy_o |-> !ana_o.sample
    && !ana_o.convert)
    else $error("analog request while sequencer idle");
  a_no_idle_slot: assert property (conv_end |-> ##[0:1]
    (ana_o.sample || !busy_o))
    else $error("gap between conversion and next sampling");
  a_sample_first: assert property (conv_begin |-> $past(ana_o.sample))
    else $error("conversion without preceding sample phase");
  a_phase_excl: assert property (!(ana_o.sample && ana_o.convert))
    else $error("sample and convert high together");
  a_irq_at_end: assert property ($rose(range_irq_o) |->
    $past(ana_o.convert))
    else $error("range flag not raised at conversion end");
  a_deep_lp_block: assert property (deep_lp_i ##1 deep_lp_i |->
    !ana_o.convert && !ana_o.sample)
    else $error("conversion active in deep low power");
  a_irq_sticky: assert property (range_irq_o && !wr_i |=> range_irq_o)
    else $error("range flag dropped without a write");
  a_rdata_slot: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its slot");
endmodule : sas_seq_ctrl_sva

bind sas_seq_ctrl sas_seq_ctrl_sva u_sva (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .deep_lp_i(deep_lp_i), .ana_o(ana_o), .ana_result_i(ana_result_i),
  .busy_o(busy_o), .range_irq_o(range_irq_o));
`default_nettype wire
